// [nir_regs.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps

// Overview of operation
// [R1] Bus options bits 11..8 read zero.
// [R2] Generation count advances after ROM change.
// [R3] Bus options bits 5..3 read zero.
// [R4] Link speed field always reads 010.
// [R5] Upper quadlet holds maker and serial high.
// [R6] Identity quadlets clear to zero at reset.
// [R7] EEPROM fills identity once, then locked.
// [R8] Without EEPROM, host loads once, then locked.
// [R9] Only global hard reset clears identity.
// [R10] Lower quadlet behaves like upper quadlet.
// [R11] ROM read address is base plus offset.
// [R12] ROM base bits 9..0 read zero.
// [R13] Max request resets to 2048 bytes, hard only.
// [R14] Writes to locked identity silently ignored.
module nir_regs
	import nir_pkg::*;
#(
	parameter int ADDR_W = NIR_ADDR_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [NIR_DATA_W-1:0] pwdata,
	input wire logic [NIR_STRB_W-1:0] pstrb,
	output logic [NIR_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eeprom_present,
	input wire nir_eeprom_load_s eeprom_load,
	input wire logic soft_reset,
	input wire logic bus_reset,
	input wire logic rom_image_changed,
	input wire nir_rom_req_s rom_rd_req,
	output nir_rom_resp_s rom_rd_resp,
	output nir_node_info_s node_info
);

	typedef struct packed
	{
		nir_id_state_e id_st;
		logic eeprom_seen;
		logic upper_lock;
		logic lower_lock;
		logic [31:0] node_id_upper;
		logic [31:0] node_id_lower;
		logic [NIR_ROM_BASE_W-1:0] rom_base;
		logic [NIR_MAXREC_W-1:0] max_rec;
		logic [NIR_GEN_W-1:0] gen;
		logic rom_dirty;
		logic [NIR_DATA_W-1:0] rdata;
		logic slverr;
	} nir_regs_state_s;

	nir_regs_state_s st_ff;
	nir_regs_state_s nxt_st;

	logic setup_ph;
	logic wr_acc;
	logic sel_bus_opt;
	logic sel_id_upper;
	logic sel_id_lower;
	logic sel_rom_base;
	logic mapped;
	logic [NIR_DATA_W-1:0] bus_opt_rd;
	logic [NIR_DATA_W-1:0] rom_base_rd;
	logic [NIR_DATA_W-1:0] rom_base_wr;
	logic host_id_load;
	logic eeprom_id_load;
	logic rom_change_evt;

	// Byte-lane merge; lanes whose strobe is low keep their old value.
	function automatic logic [31:0] nir_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// The slave never stretches a transfer, so pready stays high.
	assign pready = 1'b1;
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;

	// Only exact word offsets decode; anything else is an error.
	assign sel_bus_opt = (paddr == ADDR_W'(NIR_OFS_BUS_OPT));
	assign sel_id_upper = (paddr == ADDR_W'(NIR_OFS_ID_UPPER));
	assign sel_id_lower = (paddr == ADDR_W'(NIR_OFS_ID_LOWER));
	assign sel_rom_base = (paddr == ADDR_W'(NIR_OFS_ROM_BASE));
	assign mapped = sel_bus_opt | sel_id_upper | sel_id_lower |
		sel_rom_base;

	// Unimplemented upper bus options fields read as zero here.
	always_comb
	begin
		bus_opt_rd = 32'h0000_0000;
		bus_opt_rd[NIR_MAXREC_LSB +: NIR_MAXREC_W] = st_ff.max_rec;
		bus_opt_rd[11:8] = 4'h0; // R1
		bus_opt_rd[NIR_GEN_LSB +: NIR_GEN_W] = st_ff.gen;
		bus_opt_rd[5:3] = 3'h0; // R3
		bus_opt_rd[NIR_LNKSPD_LSB +: NIR_LNKSPD_W] = NIR_LNKSPD_CODE; // R4
	end

	always_comb
	begin
		rom_base_rd = 32'h0000_0000;
		rom_base_rd[NIR_ROM_BASE_LSB +: NIR_ROM_BASE_W] = st_ff.rom_base;
		rom_base_rd[9:0] = 10'h000; // R12
	end

	assign rom_base_wr = nir_merge(rom_base_rd, pwdata, pstrb);

	// An EEPROM load only counts while the strap chose the EEPROM path.
	assign eeprom_id_load = (st_ff.id_st == IDS_EEPROM) & eeprom_load.valid;

	// A host write that actually lands in an identity quadlet.
	assign host_id_load = (st_ff.id_st == IDS_HOST) & wr_acc &
		((sel_id_upper & ~st_ff.upper_lock) |
		(sel_id_lower & ~st_ff.lower_lock));

	assign rom_change_evt = rom_image_changed | eeprom_id_load |
		host_id_load | (wr_acc & sel_rom_base);

	always_comb
	begin
		nxt_st = st_ff;

		// Read data is sampled in the setup phase so that the access
		// phase presents it straight from a flip-flop.
		if (setup_ph)
		begin
			nxt_st.slverr = ~mapped;
			nxt_st.rdata = 32'h0000_0000;
			if (!pwrite)
			begin
				if (sel_bus_opt)
				begin
					nxt_st.rdata = bus_opt_rd;
				end
				if (sel_id_upper)
				begin
					nxt_st.rdata = st_ff.node_id_upper; // R5
				end
				if (sel_id_lower)
				begin
					nxt_st.rdata = st_ff.node_id_lower; // R10
				end
				if (sel_rom_base)
				begin
					nxt_st.rdata = rom_base_rd;
				end
			end
		end

		// Identity load and lock sequence. No software or bus reset
		// reaches these fields; only presetn clears them.
		unique case (st_ff.id_st)
			IDS_STRAP:
			begin
				// The presence strap is caught once, after release.
				nxt_st.eeprom_seen = eeprom_present;
				nxt_st.id_st = eeprom_present ? IDS_EEPROM : IDS_HOST;
			end
			IDS_EEPROM:
			begin
				// Host writes are dropped while the EEPROM owns the quadlets.
				if (eeprom_load.valid)
				begin
					nxt_st.node_id_upper = eeprom_load.upper; // R7
					nxt_st.node_id_lower = eeprom_load.lower; // R7
					nxt_st.upper_lock = 1'b1; // R7
					nxt_st.lower_lock = 1'b1; // R7
					nxt_st.id_st = IDS_LOCKED; // R7
				end
			end
			IDS_HOST:
			begin
				if (wr_acc && sel_id_upper && !st_ff.upper_lock)
				begin
					nxt_st.node_id_upper = nir_merge(st_ff.node_id_upper,
						pwdata, pstrb); // R8
					nxt_st.upper_lock = 1'b1; // R8
				end
				if (wr_acc && sel_id_lower && !st_ff.lower_lock)
				begin
					nxt_st.node_id_lower = nir_merge(st_ff.node_id_lower,
						pwdata, pstrb); // R10
					nxt_st.lower_lock = 1'b1; // R10
				end
				if (nxt_st.upper_lock && nxt_st.lower_lock)
				begin
					nxt_st.id_st = IDS_LOCKED;
				end
			end
			IDS_LOCKED:
			begin
				// Further writes fall through with no effect. R14
				nxt_st.id_st = IDS_LOCKED; // R14
			end
			default:
			begin
				// A corrupted code must never reopen the quadlets.
				nxt_st.id_st = IDS_LOCKED;
				nxt_st.upper_lock = 1'b1;
				nxt_st.lower_lock = 1'b1;
			end
		endcase

		// Bus options and ROM base writes.
		if (wr_acc && sel_bus_opt && pstrb[1])
		begin
			nxt_st.max_rec = pwdata[NIR_MAXREC_LSB +: NIR_MAXREC_W];
		end
		if (wr_acc && sel_rom_base)
		begin
			nxt_st.rom_base = rom_base_wr[NIR_ROM_BASE_LSB +:
				NIR_ROM_BASE_W];
		end

		// A change is remembered until the next bus reset bumps the
		// generation or a software reset clears it. A change in the bus
		// reset cycle itself is kept for the following reset rather than lost.
		if (bus_reset && st_ff.rom_dirty)
		begin
			nxt_st.gen = st_ff.gen + 2'h1; // R2
			nxt_st.rom_dirty = 1'b0; // R2
		end
		if (wr_acc && sel_bus_opt && pstrb[0])
		begin
			nxt_st.gen = pwdata[NIR_GEN_LSB +: NIR_GEN_W];
		end
		if (soft_reset)
		begin
			// Max request is left alone by a software reset. R13
			nxt_st.gen = NIR_GEN_RST;
			nxt_st.rom_dirty = 1'b0;
		end
		if (rom_change_evt)
		begin
			nxt_st.rom_dirty = 1'b1; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff.id_st <= IDS_STRAP;
			st_ff.eeprom_seen <= 1'b0;
			st_ff.upper_lock <= 1'b0;
			st_ff.lower_lock <= 1'b0;
			st_ff.node_id_upper <= NIR_ID_RST; // R6 R9
			st_ff.node_id_lower <= NIR_ID_RST; // R6 R9
			st_ff.rom_base <= NIR_ROM_BASE_RST;
			st_ff.max_rec <= NIR_MAXREC_RST; // R13
			st_ff.gen <= NIR_GEN_RST;
			st_ff.rom_dirty <= 1'b0;
			st_ff.rdata <= 32'h0000_0000;
			st_ff.slverr <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.rdata;
	assign pslverr = psel & penable & st_ff.slverr;

	assign node_info.node_uid = {st_ff.node_id_upper, st_ff.node_id_lower};
	assign node_info.uid_valid = (st_ff.id_st == IDS_LOCKED);
	assign node_info.max_rec = st_ff.max_rec;
	assign node_info.gen = st_ff.gen;
	assign node_info.link_speed = NIR_LNKSPD_CODE;

	// Host memory address for configuration ROM quadlet reads.
	nir_rom_addr nir_rom_addr_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.rom_base(st_ff.rom_base),
		.rd_req(rom_rd_req),
		.rd_resp(rom_rd_resp)
	);

endmodule

// [nir_pkg.sv]
package nir_pkg;

	// Register bus geometry.
	localparam int NIR_ADDR_W = 8;
	localparam int NIR_DATA_W = 32;
	localparam int NIR_STRB_W = 4;

	// Register byte offsets.
	localparam logic [7:0] NIR_OFS_BUS_OPT = 8'h20;
	localparam logic [7:0] NIR_OFS_ID_UPPER = 8'h24;
	localparam logic [7:0] NIR_OFS_ID_LOWER = 8'h28;
	localparam logic [7:0] NIR_OFS_ROM_BASE = 8'h34;

	// Bus options field positions.
	localparam int NIR_MAXREC_LSB = 12;
	localparam int NIR_MAXREC_W = 4;
	localparam int NIR_GEN_LSB = 6;
	localparam int NIR_GEN_W = 2;
	localparam int NIR_LNKSPD_LSB = 0;
	localparam int NIR_LNKSPD_W = 3;

	// Bus options reset and fixed values.
	localparam logic [3:0] NIR_MAXREC_RST = 4'hA;
	localparam logic [1:0] NIR_GEN_RST = 2'h0;
	localparam logic [2:0] NIR_LNKSPD_CODE = 3'h2;

	// Identity and ROM base layout and reset values.
	localparam logic [31:0] NIR_ID_RST = 32'h0000_0000;
	localparam int NIR_ROM_BASE_LSB = 10;
	localparam int NIR_ROM_BASE_W = 22;
	localparam logic [21:0] NIR_ROM_BASE_RST = 22'h00_0000;

	// Window of 1394 offsets served from host memory.
	localparam int NIR_OFS1394_W = 48;
	localparam logic [47:0] NIR_ROM_WIN_LO = 48'hFFFF_F000_0400;
	localparam logic [47:0] NIR_ROM_WIN_HI = 48'hFFFF_F000_07FF;

	typedef enum logic [3:0]
	{
		IDS_STRAP = 4'h1,
		IDS_EEPROM = 4'h2,
		IDS_HOST = 4'h4,
		IDS_LOCKED = 4'h8
	} nir_id_state_e;

	typedef struct packed
	{
		logic valid;
		logic [31:0] upper;
		logic [31:0] lower;
	} nir_eeprom_load_s;

	typedef struct packed
	{
		logic valid;
		logic [47:0] offset;
	} nir_rom_req_s;

	typedef struct packed
	{
		logic valid;
		logic hit;
		logic [31:0] host_addr;
	} nir_rom_resp_s;

	typedef struct packed
	{
		logic [63:0] node_uid;
		logic uid_valid;
		logic [3:0] max_rec;
		logic [1:0] gen;
		logic [2:0] link_speed;
	} nir_node_info_s;

endpackage

// [nir_rom_addr.sv]
`timescale 1ns/1ps

module nir_rom_addr
	import nir_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NIR_ROM_BASE_W-1:0] rom_base,
	input wire nir_rom_req_s rd_req,
	output nir_rom_resp_s rd_resp
);

	typedef struct packed
	{
		nir_rom_resp_s resp;
	} nir_rom_addr_state_s;

	nir_rom_addr_state_s st_ff;
	nir_rom_addr_state_s nxt_st;
	logic in_window;

	assign in_window = (rd_req.offset >= NIR_ROM_WIN_LO) &&
		(rd_req.offset <= NIR_ROM_WIN_HI);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.resp.valid = rd_req.valid;
		nxt_st.resp.hit = rd_req.valid & in_window;
		// A miss answers with address zero so no stale base leaks out.
		if (rd_req.valid && in_window)
		begin
			nxt_st.resp.host_addr = {rom_base, 10'h000} +
				{22'h00_0000, rd_req.offset[9:0]}; // R11
		end
		else
		begin
			nxt_st.resp.host_addr = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign rd_resp = st_ff.resp;

endmodule

// [nir_regs_asserts.sv]
`timescale 1ns/1ps
module nir_regs_chk
	import nir_pkg::*;
#(
	parameter int ADDR_W = NIR_ADDR_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [NIR_DATA_W-1:0] prdata,
	input wire logic eeprom_present,
	input wire nir_eeprom_load_s eeprom_load,
	input wire logic soft_reset,
	input wire logic bus_reset,
	input wire logic rom_image_changed,
	input wire nir_rom_req_s rom_rd_req,
	input wire nir_rom_resp_s rom_rd_resp,
	input wire nir_node_info_s node_info
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd, wr, hit;
	logic [9:0] lo;
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite;
	assign lo = rom_rd_req.offset[9:0];
	assign hit = rom_rd_req.offset >= NIR_ROM_WIN_LO
		&& rom_rd_req.offset <= NIR_ROM_WIN_HI;

	property p_opt;
		rd && paddr == NIR_OFS_BUS_OPT
			|-> {prdata[11:8], prdata[5:0]} == 10'h002;
	endproperty
	a_opt: assert property (p_opt)
		else $error("bus options fixed bits wrong");
	property p_base;
		rd && paddr == NIR_OFS_ROM_BASE |-> prdata[9:0] == 10'h000;
	endproperty
	a_base: assert property (p_base)
		else $error("rom base low bits set");
	property p_map;
		rom_rd_req.valid |=> rom_rd_resp.valid && rom_rd_resp.hit == $past(hit)
			&& (!rom_rd_resp.hit || rom_rd_resp.host_addr[9:0] == $past(lo));
	endproperty
	a_map: assert property (p_map)
		else $error("rom lookup wrong");
	property p_keep;
		(soft_reset || bus_reset) && !wr && !eeprom_load.valid
			|=> $stable(node_info.node_uid);
	endproperty
	a_keep: assert property (p_keep)
		else $error("identity changed by soft or bus reset");
	property p_lock;
		node_info.uid_valid |=> node_info.uid_valid
			&& $stable(node_info.node_uid);
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked identity changed");
	property p_maxrec;
		soft_reset && !wr |=> $stable(node_info.max_rec);
	endproperty
	a_maxrec: assert property (p_maxrec)
		else $error("max request changed by soft reset");
	property p_gen;
		rom_image_changed && !bus_reset && !soft_reset
			##1 bus_reset && !soft_reset && !wr
			|=> node_info.gen == $past(node_info.gen) + 2'h1;
	endproperty
	a_gen: assert property (p_gen)
		else $error("generation did not advance");
	property p_load;
		eeprom_present && eeprom_load.valid && !node_info.uid_valid
			|=> node_info.node_uid
			== {$past(eeprom_load.upper), $past(eeprom_load.lower)};
	endproperty
	a_load: assert property (p_load)
		else $error("identity not loaded from eeprom");
endmodule

// [nir_eeprom_model.sv]
`timescale 1ns/1ps
module nir_eeprom_model
	import nir_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ee_go,
	input wire logic [31:0] ee_hi,
	input wire logic [31:0] ee_lo,
	input wire logic [3:0] ee_dly,
	output nir_eeprom_load_s eeprom_load
);
	logic [4:0] cnt;

	// Outside a load the data lines keep changing, so stale data never helps.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 5'h00;
			eeprom_load <= '0;
		end
		else
		begin
			eeprom_load.valid <= (cnt == 5'h01);
			if (ee_go)
				cnt <= {1'b0, ee_dly} + 5'h01;
			else if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
			if (cnt == 5'h01)
			begin
				eeprom_load.upper <= ee_hi;
				eeprom_load.lower <= ee_lo;
			end
			else
			begin
				eeprom_load.upper <= ~eeprom_load.upper;
				eeprom_load.lower <= eeprom_load.lower ^ 32'hA5A5_5A5A;
			end
		end
	end
endmodule

// [nir_regs_bench.sv]
`timescale 1ns/1ps
module nir_regs_bench
	import nir_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, eeprom_present = 1'b0, soft_reset = 1'b0;
	logic bus_reset = 1'b0, rom_image_changed = 1'b0, ee_go = 1'b0;
	logic pready, pslverr, rhit;
	logic [3:0] pstrb = 4'hF, ee_dly = 4'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, ee_hi = 32'h0, ee_lo = 32'h0, prdata, base;
	logic [32:0] apb_q[$], rom_q[$];
	logic [47:0] ofs;
	nir_eeprom_load_s eeprom_load;
	nir_rom_req_s rom_rd_req = '0;
	nir_rom_resp_s rom_rd_resp;
	nir_node_info_s node_info;
	integer seed = 32'hD843;
	int num_errors = 0, cmp_count = 0, n;

	nir_regs nir_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .eeprom_present,
		.eeprom_load, .soft_reset, .bus_reset, .rom_image_changed,
		.rom_rd_req, .rom_rd_resp, .node_info);
	nir_eeprom_model nir_eeprom_model_i (.pclk, .presetn, .ee_go, .ee_hi,
		.ee_lo, .ee_dly, .eeprom_load);

	task automatic chk(input string nm, input logic [63:0] x, s);
		cmp_count++;
		if (s !== x)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic end_sim(input bit hung);
		if (hung)
			num_errors++;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// A write notes only its error flag; read data is meaningless then.
	task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= x[31:0];
		apb_q.push_back(w ? {x[32], 32'h0} : x);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			end_sim(1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic evs(input logic [2:0] a, input logic [2:0] b);
		{rom_image_changed, bus_reset, soft_reset} <= a;
		@(posedge pclk);
		{rom_image_changed, bus_reset, soft_reset} <= b;
		@(posedge pclk);
		{rom_image_changed, bus_reset, soft_reset} <= 3'h0;
		@(posedge pclk);
	endtask

	task automatic hrst(input logic ep);
		presetn <= 1'b0;
		eeprom_present <= ep;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1)
			chk("register", 64'(apb_q.pop_front()),
				{31'h0, pslverr, pwrite ? 32'h0 : prdata});
		if (rom_rd_resp.valid === 1'b1)
			chk("rom lookup", 64'(rom_q.pop_front()),
				{31'h0, rom_rd_resp.hit, rom_rd_resp.host_addr});
	end

	initial
	begin
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		hrst(1'b0);
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_A002});
		apb(1'b0, NIR_OFS_ID_UPPER, 33'h0);
		apb(1'b0, NIR_OFS_ID_LOWER, 33'h0);
		apb(1'b0, NIR_OFS_ROM_BASE, 33'h0);
		apb(1'b0, 8'h30, {1'b1, 32'h0});
		base = $random(seed);
		ee_hi = $random(seed);
		ee_lo = $random(seed);
		apb(1'b1, NIR_OFS_ROM_BASE, {1'b0, base});
		apb(1'b0, NIR_OFS_ROM_BASE, {1'b0, base[31:10], 10'h000});
		apb(1'b1, NIR_OFS_ID_UPPER, {1'b0, ee_hi});
		apb(1'b1, NIR_OFS_ID_LOWER, {1'b0, ee_lo});
		apb(1'b1, NIR_OFS_ID_UPPER, {1'b0, ~ee_hi});
		apb(1'b1, NIR_OFS_ID_LOWER, {1'b0, ~ee_lo});
		apb(1'b0, NIR_OFS_ID_UPPER, {1'b0, ee_hi});
		apb(1'b0, NIR_OFS_ID_LOWER, {1'b0, ee_lo});
		chk("identity", {ee_hi, ee_lo}, node_info.node_uid);
		for (int i = 0; i < 8; i++)
		begin
			ofs = {NIR_ROM_WIN_LO[47:12], i[0], 1'b1, 10'($random(seed))};
			if (i < 4)
				ofs = NIR_ROM_WIN_LO - 48'h1 + 48'(i[0]) + 48'(i[1] * 1024);
			rom_rd_req <= {1'b1, ofs};
			rhit = ofs >= NIR_ROM_WIN_LO && ofs <= NIR_ROM_WIN_HI;
			rom_q.push_back({rhit, rhit ? {base[31:10], 10'h000}
				+ {22'h0, ofs[9:0]} : 32'h0});
			@(posedge pclk);
		end
		rom_rd_req <= '0;
		@(posedge pclk);
		evs(3'h2, 3'h0);
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_A042});
		evs(3'h2, 3'h0);
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_A042});
		evs(3'h4, 3'h2);
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_A082});
		apb(1'b1, NIR_OFS_BUS_OPT, {1'b0, 32'hFFFF_FFFF});
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_F0C2});
		evs(3'h1, 3'h0);
		apb(1'b0, NIR_OFS_BUS_OPT, {1'b0, 32'h0000_F002});
		apb(1'b0, NIR_OFS_ID_UPPER, {1'b0, ee_hi});
		hrst(1'b1);
		apb(1'b0, NIR_OFS_ID_LOWER, 33'h0);
		ee_hi = $random(seed);
		ee_lo = $random(seed);
		ee_dly = 4'($random(seed));
		ee_go <= 1'b1;
		@(posedge pclk);
		ee_go <= 1'b0;
		n = 0;
		while (node_info.uid_valid !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50)
			end_sim(1'b1);
		apb(1'b1, NIR_OFS_ID_UPPER, {1'b0, ~ee_hi});
		apb(1'b0, NIR_OFS_ID_UPPER, {1'b0, ee_hi});
		apb(1'b0, NIR_OFS_ID_LOWER, {1'b0, ee_lo});
		end_sim(1'b0);
	end
endmodule

bind nir_regs nir_regs_chk #(.ADDR_W(ADDR_W)) nir_regs_chk_i (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .prdata, .eeprom_present,
	.eeprom_load, .soft_reset, .bus_reset, .rom_image_changed, .rom_rd_req,
	.rom_rd_resp, .node_info);
